/* rtl/aacb_defs.svh */
// What this block does
// - literal AND opcode is 0000 1011 plus 8-bit literal, ANDed with W
// - literal AND writes W, touches only N and Z, one word, one cycle
// - file AND prefix 0001 01, then d, a, 8-bit file; d=0 writes W
// - file AND with d=1 writes back the file register; only N, Z change
// - a=0 selects the access bank, bank select register ignored
// - a=1 forms the address from bank select register and file field
// - a=0, extended set on, file at most 95: indexed literal offset
// - carry branch is 1110 0010 plus signed offset; no flags change
// - taken carry branch: PC becomes incremented PC plus two times offset
// - taken branch is two cycles, second all no-ops; not taken is one
// - four phases: decode, read operand, process, write destination
`ifndef AACB_DEFS_SVH
`define AACB_DEFS_SVH

`define AACB_OP_AND_LIT   8'h0b
`define AACB_OP_AND_FILE  6'h05
`define AACB_OP_BR_CARRY  8'he2
`define AACB_ILO_MAX      8'h5f
`define AACB_ACC_HI_BANK  4'hf
`define AACB_ACC_LO_BANK  4'h0
`define AACB_PC_STEP      21'h0_0002
`define AACB_PC_RST       21'h0_0000
// all ones out of reset, so the first AND shows its operand
`define AACB_W_RST        8'hff
`define AACB_ZERO8        8'h00
`define AACB_ADDR_RST     12'h000
`define AACB_SIGN_BIT     7
`define AACB_OFS_EXT      12

`endif

/* rtl/aacb_pkg.sv */
package aacb_pkg;

  typedef enum logic [1:0] {
    AACB_PH_Q1 = 2'b00,
    AACB_PH_Q2 = 2'b01,
    AACB_PH_Q3 = 2'b10,
    AACB_PH_Q4 = 2'b11
  } aacb_phase_e;

  typedef enum logic [1:0] {
    AACB_K_NOP      = 2'b00,
    AACB_K_AND_LIT  = 2'b01,
    AACB_K_AND_FILE = 2'b10,
    AACB_K_BR_CARRY = 2'b11
  } aacb_kind_e;

  typedef struct packed {
    logic [5:0] pfx;
    logic       dst;
    logic       acc;
    logic [7:0] lit;
  } aacb_word_s;

  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic c;
  } aacb_flags_s;

  typedef struct packed {
    aacb_kind_e kind;
    logic       dst;
    logic [7:0] lit;
  } aacb_dec_s;

endpackage : aacb_pkg

/* rtl/aacb_data_ram.sv */
`timescale 1ns/10ps
module aacb_data_ram (
  input  wire logic        core_clk,
  input  wire logic        wr_en,
  input  wire logic [11:0] wr_addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic [11:0] rd_addr,
  output logic      [7:0]  rd_data_q
);
  // no reset on the array: contents are undefined until loaded
  logic [7:0] mem [0:4095];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_q <= mem[rd_addr];
  end
endmodule : aacb_data_ram

/* rtl/aacb_core.sv */
`timescale 1ns/10ps
`include "aacb_defs.svh"
module aacb_core (
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  input  wire logic                 instr_valid,
  input  wire aacb_pkg::aacb_word_s instr,
  input  wire logic                 ext_set_en,
  input  wire logic [3:0]           bank_sel,
  input  wire logic [11:0]          index_base,
  input  wire logic                 flag_wr_en,
  input  wire aacb_pkg::aacb_flags_s flag_wdata,
  input  wire logic                 load_en,
  input  wire logic [11:0]          load_addr,
  input  wire logic [7:0]           load_data,
  input  wire logic [11:0]          peek_addr,
  output logic                      instr_ready_q,
  output logic                      retire_q,
  output logic [7:0]                w_q,
  output aacb_pkg::aacb_flags_s     flags_q,
  output logic [20:0]               pc_q,
  output logic [7:0]                peek_data_q
);

  // ******************************************************
  // functions
  // ******************************************************
  function automatic aacb_pkg::aacb_kind_e decode(
    input aacb_pkg::aacb_word_s w
  );
    if ({w.pfx, w.dst, w.acc} == `AACB_OP_AND_LIT) begin
      decode = aacb_pkg::AACB_K_AND_LIT;
    end else if (w.pfx == `AACB_OP_AND_FILE) begin
      decode = aacb_pkg::AACB_K_AND_FILE;
    end else if ({w.pfx, w.dst, w.acc} == `AACB_OP_BR_CARRY) begin
      decode = aacb_pkg::AACB_K_BR_CARRY;
    end else begin
      decode = aacb_pkg::AACB_K_NOP;
    end
  endfunction : decode

  function automatic logic [11:0] form_addr(
    input logic       acc,
    input logic [7:0] f,
    input logic [3:0] bank,
    input logic [11:0] base,
    input logic       ext
  );
    if (acc) begin
      form_addr = {bank, f};
    end else if (ext && f <= `AACB_ILO_MAX) begin
      form_addr = base + {4'h0, f};
    end else if (f <= `AACB_ILO_MAX) begin
      form_addr = {`AACB_ACC_LO_BANK, f};
    end else begin
      form_addr = {`AACB_ACC_HI_BANK, f};
    end
  endfunction : form_addr

  function automatic aacb_pkg::aacb_flags_s and_flags(
    input aacb_pkg::aacb_flags_s old,
    input logic [7:0]            res
  );
    and_flags    = old;
    and_flags.z  = (res == `AACB_ZERO8);
    and_flags.n  = res[`AACB_SIGN_BIT];
  endfunction : and_flags

  // ******************************************************
  // phase sequencer and datapath
  // ******************************************************
  aacb_pkg::aacb_phase_e phase_q, phase_d;
  aacb_pkg::aacb_dec_s   ins_q, ins_d;
  aacb_pkg::aacb_flags_s flags_d;
  logic                  live_q, live_d;
  logic                  nop_q, nop_d;
  logic [11:0]           addr_q, addr_d;
  logic [7:0]            res_q, res_d;
  logic [7:0]            w_d;
  logic [20:0]           pc_d;
  logic                  ready_d;
  logic                  retire_d;
  logic                  mem_wr_en;
  logic [11:0]           mem_wr_addr;
  logic [7:0]            mem_wr_data;
  logic [11:0]           rd_addr;
  logic [7:0]            rd_data;
  logic                  taken;
  logic                  peek_rd_q, peek_rd_d;
  logic [7:0]            peek_d;

  assign taken = live_q && ins_q.kind == aacb_pkg::AACB_K_BR_CARRY
                 && flags_q.c;

  always_comb begin
    phase_d     = phase_q;
    ins_d       = ins_q;
    live_d      = live_q;
    nop_d       = nop_q;
    addr_d      = addr_q;
    res_d       = res_q;
    w_d         = w_q;
    pc_d        = pc_q;
    ready_d     = instr_ready_q;
    retire_d    = 1'b0;
    flags_d     = flag_wr_en ? flag_wdata : flags_q;
    // preload shares the write port; the instruction wins in Q4
    mem_wr_en   = load_en;
    mem_wr_addr = load_addr;
    mem_wr_data = load_data;
    rd_addr     = peek_addr;
    peek_rd_d   = 1'b1;
    case (phase_q)
      aacb_pkg::AACB_PH_Q1: begin
        phase_d = aacb_pkg::AACB_PH_Q2;
        ready_d = 1'b0;
        live_d  = !nop_q && instr_valid;
        if (!nop_q && instr_valid) begin
          ins_d.kind = decode(instr);
          ins_d.dst  = instr.dst;
          ins_d.lit  = instr.lit;
          addr_d     = form_addr(instr.acc, instr.lit, bank_sel,
                                 index_base, ext_set_en);
          pc_d       = pc_q + `AACB_PC_STEP;
        end
      end
      aacb_pkg::AACB_PH_Q2: begin
        phase_d = aacb_pkg::AACB_PH_Q3;
        if (live_q && ins_q.kind == aacb_pkg::AACB_K_AND_FILE) begin
          rd_addr   = addr_q;
          peek_rd_d = 1'b0;
        end
      end
      aacb_pkg::AACB_PH_Q3: begin
        phase_d = aacb_pkg::AACB_PH_Q4;
        if (ins_q.kind == aacb_pkg::AACB_K_AND_FILE) begin
          res_d = w_q & rd_data;
        end else begin
          res_d = w_q & ins_q.lit;
        end
      end
      aacb_pkg::AACB_PH_Q4: begin
        phase_d  = aacb_pkg::AACB_PH_Q1;
        retire_d = live_q;
        ready_d  = nop_q || !taken;
        nop_d    = !nop_q && taken;
        if (live_q) begin
          case (ins_q.kind)
            aacb_pkg::AACB_K_AND_LIT: begin
              w_d     = res_q;
              flags_d = and_flags(flags_q, res_q);
            end
            aacb_pkg::AACB_K_AND_FILE: begin
              flags_d = and_flags(flags_q, res_q);
              if (ins_q.dst) begin
                mem_wr_en   = 1'b1;
                mem_wr_addr = addr_q;
                mem_wr_data = res_q;
              end else begin
                w_d = res_q;
              end
            end
            aacb_pkg::AACB_K_BR_CARRY: begin
              if (taken) begin
                // pc_q already holds the address after the branch
                pc_d = pc_q + 21'({{`AACB_OFS_EXT{ins_q.lit[`AACB_SIGN_BIT]}},
                                  ins_q.lit, 1'b0});
              end
            end
            default: begin
              w_d = w_q;
            end
          endcase
        end
      end
      default: begin
        phase_d = aacb_pkg::AACB_PH_Q1;
      end
    endcase
    peek_d = peek_rd_q ? rd_data : peek_data_q;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      phase_q       <= aacb_pkg::AACB_PH_Q1;
      ins_q         <= '0;
      live_q        <= 1'b0;
      nop_q         <= 1'b0;
      addr_q        <= `AACB_ADDR_RST;
      res_q         <= `AACB_ZERO8;
      w_q           <= `AACB_W_RST;
      pc_q          <= `AACB_PC_RST;
      flags_q       <= '0;
      instr_ready_q <= 1'b1;
      retire_q      <= 1'b0;
      peek_rd_q     <= 1'b0;
      peek_data_q   <= `AACB_ZERO8;
    end else begin
      phase_q       <= phase_d;
      ins_q         <= ins_d;
      live_q        <= live_d;
      nop_q         <= nop_d;
      addr_q        <= addr_d;
      res_q         <= res_d;
      w_q           <= w_d;
      pc_q          <= pc_d;
      flags_q       <= flags_d;
      instr_ready_q <= ready_d;
      retire_q      <= retire_d;
      peek_rd_q     <= peek_rd_d;
      peek_data_q   <= peek_d;
    end
  end

  aacb_data_ram aacb_data_ram_i (
    .core_clk  (core_clk),
    .wr_en     (mem_wr_en),
    .wr_addr   (mem_wr_addr),
    .wr_data   (mem_wr_data),
    .rd_addr   (rd_addr),
    .rd_data_q (rd_data)
  );

  // ******************************************************
  // checks
  // ******************************************************
  logic q4_and;
  assign q4_and = phase_q == aacb_pkg::AACB_PH_Q4 && live_q
                  && ins_q.kind != aacb_pkg::AACB_K_NOP
                  && ins_q.kind != aacb_pkg::AACB_K_BR_CARRY;

  a_phase_walk: assert property (
    @(posedge core_clk) disable iff (!nrst)
    phase_q == aacb_pkg::AACB_PH_Q1 |=> phase_q == aacb_pkg::AACB_PH_Q2
      ##1 phase_q == aacb_pkg::AACB_PH_Q3 ##1 phase_q == aacb_pkg::AACB_PH_Q4)
    else $error("phase order broken");

  a_lit_into_w: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (phase_q == aacb_pkg::AACB_PH_Q3 && live_q
     && ins_q.kind == aacb_pkg::AACB_K_AND_LIT)
    |-> ##2 w_q == ($past(w_q, 2) & $past(ins_q.lit, 2)))
    else $error("literal and result wrong");

  a_and_flags: assert property (
    @(posedge core_clk) disable iff (!nrst)
    q4_and |=> flags_q.z == ($past(res_q) == `AACB_ZERO8)
      && flags_q.n == $past(res_q[`AACB_SIGN_BIT])
      && flags_q.c == $past(flags_q.c) && flags_q.ov == $past(flags_q.ov))
    else $error("and flag update wrong");

  a_file_dest: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (q4_and && ins_q.kind == aacb_pkg::AACB_K_AND_FILE && ins_q.dst)
    |-> mem_wr_en && mem_wr_addr == addr_q ##1 w_q == $past(w_q))
    else $error("file write back wrong");

  a_bank_addr: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (phase_q == aacb_pkg::AACB_PH_Q1 && !nop_q && instr_valid && instr.acc)
    |=> addr_q == {$past(bank_sel), $past(instr.lit)})
    else $error("banked address wrong");

  a_index_addr: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (phase_q == aacb_pkg::AACB_PH_Q1 && !nop_q && instr_valid && !instr.acc
     && ext_set_en && instr.lit <= `AACB_ILO_MAX)
    |=> addr_q == $past(index_base) + {4'h0, $past(instr.lit)})
    else $error("indexed address wrong");

  a_br_target: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (phase_q == aacb_pkg::AACB_PH_Q4 && taken)
    |=> pc_q == $past(pc_q)
        + 21'({{`AACB_OFS_EXT{$past(ins_q.lit[`AACB_SIGN_BIT])}},
               $past(ins_q.lit), 1'b0}))
    else $error("branch target wrong");

  a_br_two_cyc: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (phase_q == aacb_pkg::AACB_PH_Q4 && taken)
    |=> (nop_q && !live_d && !instr_ready_q) [*4] ##1 instr_ready_q)
    else $error("taken branch not two cycles");

  a_br_no_flag: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (phase_q == aacb_pkg::AACB_PH_Q4 && live_q && !flag_wr_en
     && ins_q.kind == aacb_pkg::AACB_K_BR_CARRY)
    |=> flags_q == $past(flags_q) && (nop_q == $past(flags_q.c)))
    else $error("branch touched flags or timing");
endmodule : aacb_core

/* tb/test_and_and_carry_branch_decode.sv */
`timescale 1ns/10ps
`include "aacb_defs.svh"
module test_and_and_carry_branch_decode;
  logic                  core_clk = 1'b0;
  logic                  nrst, instr_valid, ext_set_en, flag_wr_en, load_en;
  aacb_pkg::aacb_word_s  instr;
  aacb_pkg::aacb_flags_s flag_wdata, flags_q;
  logic [3:0]            bank_sel, fexp;
  logic [11:0]           index_base, load_addr, peek_addr;
  logic [7:0]            load_data, w_q, peek_data_q, w_exp;
  logic                  instr_ready_q, retire_q, rdy;
  logic [20:0]           pc_q, pc_exp;
  int                    n_mismatch, samples_checked;

  aacb_core aacb_core_i (.core_clk(core_clk), .nrst(nrst),
    .instr_valid(instr_valid), .instr(instr), .ext_set_en(ext_set_en),
    .bank_sel(bank_sel), .index_base(index_base), .flag_wr_en(flag_wr_en),
    .flag_wdata(flag_wdata), .load_en(load_en), .load_addr(load_addr),
    .load_data(load_data), .peek_addr(peek_addr),
    .instr_ready_q(instr_ready_q), .retire_q(retire_q), .w_q(w_q),
    .flags_q(flags_q), .pc_q(pc_q), .peek_data_q(peek_data_q));

  always #12.5 core_clk = ~core_clk;

  // ****************************************
  // shared tasks
  // ****************************************
  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  task chk(input string nm, input logic [20:0] e, input logic [20:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task set_flags(input logic [3:0] f);
    @(posedge core_clk);
    flag_wr_en <= 1'b1;
    flag_wdata <= f;
    @(posedge core_clk);
    flag_wr_en <= 1'b0;
  endtask : set_flags

  task poke(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    load_en   <= 1'b1;
    load_addr <= a;
    load_data <= d;
    @(posedge core_clk);
    load_en <= 1'b0;
  endtask : poke

  task peek(input logic [11:0] a, input logic [7:0] e);
    @(posedge core_clk);
    peek_addr <= a;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    chk("peek_data_q", {13'h0, e}, {13'h0, peek_data_q});
  endtask : peek

  // holds the word until the Q1 edge that takes it; rdy is ready after Q4
  task issue(input logic [15:0] wd, input logic ext, input logic [3:0] bk,
             input logic [11:0] base);
    int k;
    @(posedge core_clk);
    instr       <= wd;
    instr_valid <= 1'b1;
    ext_set_en  <= ext;
    bank_sel    <= bk;
    index_base  <= base;
    k = 0;
    @(negedge core_clk);
    while (instr_ready_q !== 1'b1 && k < 20) begin
      @(negedge core_clk);
      k++;
    end
    chk("instr_ready_q", 21'h1, {20'h0, instr_ready_q});
    @(posedge core_clk);
    instr_valid <= 1'b0;
    pc_exp = pc_exp + 21'h0_0002;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    rdy = instr_ready_q;
    // retire pulse stands only in the Q1 right after the Q4 edge
    chk("retire_q", 21'h1, {20'h0, retire_q});
    @(negedge core_clk);
    chk("retire_q", 21'h0, {20'h0, retire_q});
  endtask : issue

  // ****************************************
  // scenarios
  // ****************************************
  task t_lit(input logic [7:0] k, input logic [3:0] fin);
    set_flags(fin);
    w_exp = w_exp & k;
    fexp  = {w_exp[7], fin[2], w_exp == 8'h00, fin[0]};
    issue({8'h0b, k}, 1'b0, 4'h0, 12'h000);
    chk("w_q", {13'h0, w_exp}, {13'h0, w_q});
    chk("flags_q", {17'h0, fexp}, {17'h0, flags_q});
    chk("pc_q", pc_exp, pc_q);
    chk("ready", 21'h1, {20'h0, rdy});
    $display("test literal and %h done", k);
  endtask : t_lit

  // target holds a5, decoy 3c: only the chosen byte may change
  task t_file(input logic d, input logic a, input logic [7:0] f,
              input logic [3:0] bk, input logic ext, input logic [11:0] tgt,
              input logic [11:0] dcy);
    logic [7:0] res;
    res  = w_exp & 8'ha5;
    fexp = {res[7], 1'b0, res == 8'h00, 1'b1};
    poke(tgt, 8'ha5);
    poke(dcy, 8'h3c);
    set_flags(4'h3);
    issue({6'h05, d, a, f}, ext, bk, 12'h200);
    if (!d)
      w_exp = res;
    chk("flags_q", {17'h0, fexp}, {17'h0, flags_q});
    chk("w_q", {13'h0, w_exp}, {13'h0, w_q});
    peek(tgt, d ? res : 8'ha5);
    peek(dcy, 8'h3c);
    $display("test file and %h done", tgt);
  endtask : t_file

  // a prefix one bit off the file AND must do nothing but step the pc
  task t_nop;
    set_flags(4'h5);
    issue(16'h1100, 1'b0, 4'h0, 12'h000);
    chk("w_q", {13'h0, w_exp}, {13'h0, w_q});
    chk("flags_q", 21'h5, {17'h0, flags_q});
    chk("pc_q", pc_exp, pc_q);
    $display("test unknown opcode done");
  endtask : t_nop

  task t_br(input logic c, input logic [7:0] n);
    logic [20:0] here;
    set_flags({3'b010, c});
    here = pc_exp;
    issue({8'he2, n}, 1'b0, 4'h0, 12'h000);
    if (c)
      pc_exp = here + 21'h0_0002 + {{12{n[7]}}, n, 1'b0};
    chk("pc_q", pc_exp, pc_q);
    chk("ready", {20'h0, !c}, {20'h0, rdy});
    chk("flags_q", {17'h0, 3'b010, c}, {17'h0, flags_q});
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk("ready", 21'h1, {20'h0, instr_ready_q});
    chk("pc_q", pc_exp, pc_q);
    $display("test branch %b %h done", c, n);
  endtask : t_br

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    nrst        = 1'b0;
    instr_valid = 1'b0;
    instr       = 16'h0000;
    ext_set_en  = 1'b0;
    bank_sel    = 4'h0;
    index_base  = 12'h000;
    flag_wr_en  = 1'b0;
    flag_wdata  = 4'h0;
    load_en     = 1'b0;
    load_addr   = 12'h000;
    load_data   = 8'h00;
    peek_addr   = 12'h000;
    pc_exp      = 21'h0_0000;
    w_exp       = `AACB_W_RST;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    t_lit(8'hc3, 4'h7);
    t_file(1'b1, 1'b1, 8'h12, 4'h3, 1'b1, 12'h312, 12'h012);
    t_file(1'b1, 1'b0, 8'h20, 4'h7, 1'b0, 12'h020, 12'h720);
    t_file(1'b1, 1'b0, 8'h80, 4'h7, 1'b0, 12'hf80, 12'h780);
    t_file(1'b1, 1'b0, 8'h5f, 4'h7, 1'b1, 12'h25f, 12'h05f);
    t_file(1'b1, 1'b0, 8'h60, 4'h7, 1'b1, 12'hf60, 12'h260);
    t_file(1'b0, 1'b1, 8'h55, 4'h1, 1'b0, 12'h155, 12'h055);
    t_lit(8'h7e, 4'hc);
    t_nop();
    t_br(1'b0, 8'h05);
    t_br(1'b1, 8'h05);
    t_br(1'b1, 8'h80);
    t_br(1'b1, 8'h7f);
    complete_run();
  end

  // whole run is well under 2000 cycles
  initial begin
    #(25 * 8000);
    n_mismatch++;
    complete_run();
  end
endmodule : test_and_and_carry_branch_decode
